// ===== logic/slm_pkg.sv
// slm_pkg: constants and types of the serial link lane error monitor
// assumes a plain register port with byte data and 12-bit addresses
//
// Behaviour
// [RL1] auto clear resets only the counter that tripped sync request, others untouched
// [RL2] auto clear control resets disabled, tripped counters keep their value
// [RL3] every link error control exists once per link, chosen by link page select
// [RL4] software changes these controls only while decoder core is in soft reset; the monitor accepts writes at any time
// [RL5] eight-bit ilas multiframe count, groups of four multiframes, resets to one
// [RL6] eight-bit error threshold resets to all ones, sets trip count
// [RL7] counts reaching threshold raise interrupt or sync request error
// [RL8] sync request asserts when any lane counter reaches threshold and mask bit set
// [RL9] mask bits: 2 bad disparity, 1 not in table, 0 unexpected control
// [RL10] lane 0 enables bits 5 unexpected, 4 not in table, 3 disparity, reset set
// [RL11] lane 0 clears bits 2 disparity, 1 not in table, 0 unexpected, reset set
// [RL12] queued test mode off reports simultaneous lane errors as one error
// [RL13] enabled counters saturate, hold when disabled, clear to zero while clear bit set
package slm_pkg;
   localparam int unsigned num_links = 2;
   localparam int unsigned num_lanes = 8;
   localparam int unsigned num_types = 3;
   localparam logic [11:0] adr_link_page = 12'h0300;
   localparam logic [11:0] adr_decoder_control = 12'h0475;
   localparam logic [11:0] adr_link_control_low = 12'h0477;
   localparam logic [11:0] adr_ilas_count = 12'h0478;
   localparam logic [11:0] adr_threshold = 12'h047c;
   localparam logic [11:0] adr_sync_mask = 12'h047d;
   localparam logic [11:0] adr_lane0_control = 12'h0480;
   localparam logic [11:0] adr_irq_status = 12'h0490;
   localparam logic [11:0] adr_irq_clear = 12'h0491;
   localparam logic [11:0] adr_irq_enable = 12'h0492;
   localparam logic [11:0] adr_lane0_count_base = 12'h04a0;
   localparam int unsigned pos_soft_reset = 3;
   localparam int unsigned pos_auto_clear = 3;
   localparam int unsigned pos_queued_test = 4;
   localparam int unsigned pos_enables = 3;
   localparam logic [7:0] rst_ilas_count = 8'h01;
   localparam logic [7:0] rst_threshold = 8'hff;
   localparam logic [2:0] rst_sync_mask = 3'h7;
   localparam logic [2:0] rst_enables = 3'h7;
   localparam logic [2:0] rst_clears = 3'h7;
   localparam logic rst_auto_clear = 1'b0;
   localparam logic rst_soft_reset = 1'b1;
   // counter type index: 0 unexpected control, 1 not in table, 2 bad disparity
   typedef enum logic [1:0] {
      slm_uek_type = 2'h0,
      slm_nit_type = 2'h1,
      slm_bde_type = 2'h2
   } slm_err_type;
endpackage

// ===== logic/slm_cnt_if.sv
// slm_cnt_if: signals between the register block and the lane 0 counters
// assumes one clock domain
`timescale 1ns/1ps
interface slm_cnt_if;
   logic [2:0] err;
   logic [2:0] ena;
   logic [2:0] clr;
   logic [2:0] auto_clr;
   logic [7:0] thresh;
   logic [23:0] count;
   logic [2:0] hit;
   modport ctl (output err, output ena, output clr, output auto_clr, output thresh, input count, input hit);
   modport cnt (input err, input ena, input clr, input auto_clr, input thresh, output count, output hit);
endinterface

// ===== logic/slm_counters.sv
// slm_counters: three saturating error counters for lane 0
// assumes error pulses already synchronous to clock_in
`timescale 1ns/1ps
module slm_counters (
   input wire logic clock_in,
   input wire logic rstn_in,
   slm_cnt_if.cnt bus
);
   import slm_pkg::*;
   logic [7:0] cnt_ff [num_types];
   logic [7:0] nxt_cnt [num_types];
   genvar g;
   generate
      for (g = 0; g < num_types; g++) begin : g_cnt
         always_comb begin
            nxt_cnt[g] = cnt_ff[g];
            if (bus.clr[g] || bus.auto_clr[g]) begin
               nxt_cnt[g] = 8'h00; // RL1 RL11
            end else if (bus.ena[g] && bus.err[g] && cnt_ff[g] != 8'hff) begin
               nxt_cnt[g] = cnt_ff[g] + 8'h01; // RL13
            end
         end
         always_ff @(posedge clock_in or negedge rstn_in) begin
            if (!rstn_in) begin
               cnt_ff[g] <= 8'h00;
            end else begin
               cnt_ff[g] <= nxt_cnt[g];
            end
         end
         assign bus.count[g*8 +: 8] = cnt_ff[g];
         assign bus.hit[g] = cnt_ff[g] >= bus.thresh; // RL6 RL7
      end
   endgenerate
endmodule

// ===== logic/slm_monitor.sv
// slm_monitor: lane error monitor, paged link controls, sync request and interrupt
// assumes error inputs come from the decoder on another timing, so they are synchronised
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module slm_monitor (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic [11:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic bad_disparity_error_in,
   input wire logic not_in_table_error_in,
   input wire logic unexpected_control_char_error_in,
   output logic sync_request_out,
   output logic interrupt_out,
   output logic [7:0] ilas_multiframe_groups_out,
   output logic lane_decoder_core_reset_out,
   output logic error_report_out
);
   import slm_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // register state
   typedef struct packed {
      logic auto_clear;
      logic queued_test;
      logic [7:0] ilas;
      logic [7:0] thresh;
      logic [2:0] mask;
      logic [2:0] ena;
      logic [2:0] clr;
   } slm_link_type;

   slm_link_type link_ff [num_links];
   slm_link_type nxt_link [num_links];
   logic page_ff, nxt_page;
   logic soft_rst_ff, nxt_soft_rst;
   logic [2:0] sts_ff, nxt_sts;
   logic [2:0] ien_ff, nxt_ien;
   logic [7:0] rdata_ff, nxt_rdata;
   logic sync_ff, nxt_sync;
   logic rep_ff, nxt_rep;
   logic [2:0] s1_ff, s2_ff;
   logic [2:0] trip;
   slm_link_type act;
   slm_cnt_if cif ();

   // enable field runs unexpected..disparity from bit 5 down, clear field disparity..unexpected;
   // reverse the enables so index 0 is always unexpected control
   function automatic logic [2:0] rev3(input logic [2:0] v);
      rev3 = {v[0], v[1], v[2]};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s1_ff <= 3'h0;
         s2_ff <= 3'h0;
      end else begin
         s1_ff <= {bad_disparity_error_in, not_in_table_error_in, unexpected_control_char_error_in};
         s2_ff <= s1_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counters on the active link page
   assign act = link_ff[page_ff]; // RL3
   assign cif.err = s2_ff;
   assign cif.ena = rev3(act.ena); // RL10
   assign cif.clr = act.clr; // RL11
   assign cif.thresh = act.thresh;
   // mask bit 2 disparity, 0 unexpected matches counter index order
   assign trip = cif.hit & act.mask; // RL8 RL9
   assign cif.auto_clr = act.auto_clear ? trip : 3'h0; // RL1

   slm_counters u_cnt (
      .clock_in(clock_in),
      .rstn_in(rstn_in),
      .bus(cif.cnt)
   );

   ////////////////////////////////////////////////////////////////////////
   // register writes and reads
   always_comb begin
      for (int i = 0; i < num_links; i++) begin
         nxt_link[i] = link_ff[i];
      end
      nxt_page = page_ff;
      nxt_soft_rst = soft_rst_ff;
      nxt_ien = ien_ff;
      nxt_rdata = 8'h00;
      nxt_sts = sts_ff;
      if (wr_in) begin
         // RL4: software writes link controls only under soft reset; not enforced here
         case (addr_in)
            adr_link_page: nxt_page = wdata_in[0];
            adr_decoder_control: nxt_soft_rst = wdata_in[pos_soft_reset];
            adr_link_control_low: begin
               nxt_link[page_ff].auto_clear = wdata_in[pos_auto_clear]; // RL3
               nxt_link[page_ff].queued_test = wdata_in[pos_queued_test];
            end
            adr_ilas_count: nxt_link[page_ff].ilas = wdata_in; // RL5
            adr_threshold: nxt_link[page_ff].thresh = wdata_in; // RL6
            adr_sync_mask: nxt_link[page_ff].mask = wdata_in[2:0]; // RL9
            adr_lane0_control: begin
               nxt_link[page_ff].ena = wdata_in[5:3]; // RL10
               nxt_link[page_ff].clr = wdata_in[2:0]; // RL11
            end
            adr_irq_clear: nxt_sts = sts_ff & ~wdata_in[2:0];
            adr_irq_enable: nxt_ien = wdata_in[2:0];
            default: ;
         endcase
      end
      nxt_sts = nxt_sts | cif.hit; // RL7
      if (rd_in) begin
         case (addr_in)
            adr_link_page: nxt_rdata = {7'h00, page_ff};
            adr_decoder_control: nxt_rdata = 8'(soft_rst_ff) << pos_soft_reset;
            adr_link_control_low: nxt_rdata = {3'h0, act.queued_test, act.auto_clear, 3'h0};
            adr_ilas_count: nxt_rdata = act.ilas;
            adr_threshold: nxt_rdata = act.thresh;
            adr_sync_mask: nxt_rdata = {5'h00, act.mask};
            adr_lane0_control: nxt_rdata = {2'h0, act.ena, act.clr};
            adr_irq_status: nxt_rdata = {5'h00, sts_ff};
            adr_irq_enable: nxt_rdata = {5'h00, ien_ff};
            adr_lane0_count_base: nxt_rdata = cif.count[7:0];
            adr_lane0_count_base + 12'h001: nxt_rdata = cif.count[15:8];
            adr_lane0_count_base + 12'h002: nxt_rdata = cif.count[23:16];
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sync request and error report
   always_comb begin
      nxt_sync = |trip; // RL8
      // one pulse per cycle however many error types flag at once
      nxt_rep = |(s2_ff & cif.ena); // RL12
      if (act.queued_test) begin
         nxt_rep = |s2_ff;
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < num_links; i++) begin
            link_ff[i].auto_clear <= rst_auto_clear; // RL2
            link_ff[i].queued_test <= 1'b0;
            link_ff[i].ilas <= rst_ilas_count; // RL5
            link_ff[i].thresh <= rst_threshold; // RL6
            link_ff[i].mask <= rst_sync_mask;
            link_ff[i].ena <= rst_enables; // RL10
            link_ff[i].clr <= rst_clears; // RL11
         end
         page_ff <= 1'b0;
         soft_rst_ff <= rst_soft_reset;
         sts_ff <= 3'h0;
         ien_ff <= 3'h0;
         rdata_ff <= 8'h00;
         sync_ff <= 1'b0;
         rep_ff <= 1'b0;
      end else begin
         link_ff <= nxt_link;
         page_ff <= nxt_page;
         soft_rst_ff <= nxt_soft_rst;
         sts_ff <= nxt_sts;
         ien_ff <= nxt_ien;
         rdata_ff <= nxt_rdata;
         sync_ff <= nxt_sync;
         rep_ff <= nxt_rep;
      end
   end

   assign rdata_out = rdata_ff;
   assign sync_request_out = sync_ff;
   assign interrupt_out = |(sts_ff & ien_ff); // RL7
   assign ilas_multiframe_groups_out = act.ilas;
   assign lane_decoder_core_reset_out = soft_rst_ff;
   assign error_report_out = rep_ff;
endmodule

// ===== testbench/slm_props.sv
// slm_props: concurrent checks on the monitor's ports
// assumes one clock domain and an async active-low reset
`timescale 1ns/1ps
module slm_props
   import slm_pkg::*;
(
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic [11:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic bad_disparity_error_in,
   input wire logic not_in_table_error_in,
   input wire logic unexpected_control_char_error_in,
   input wire logic sync_request_out,
   input wire logic interrupt_out,
   input wire logic [7:0] ilas_multiframe_groups_out,
   input wire logic lane_decoder_core_reset_out,
   input wire logic error_report_out
);
   logic [3:0] evt_ff, nxt_evt, err_ff, nxt_err;
   logic touched_ff, nxt_touched, any_err;
   ////////////////////////////////////////////////////////////////////////////////
   // cycles since last error pin or write, and auto clear touched
   always_comb begin
      any_err = bad_disparity_error_in | not_in_table_error_in | unexpected_control_char_error_in;
      nxt_evt = (any_err || wr_in) ? 4'h0 : ((evt_ff == 4'hf) ? evt_ff : evt_ff + 4'h1);
      nxt_err = any_err ? 4'h0 : ((err_ff == 4'hf) ? err_ff : err_ff + 4'h1);
      nxt_touched = touched_ff | (wr_in && addr_in == adr_link_control_low);
   end
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         evt_ff <= 4'hf;
         err_ff <= 4'hf;
         touched_ff <= 1'b0;
      end else begin
         evt_ff <= nxt_evt;
         err_ff <= nxt_err;
         touched_ff <= nxt_touched;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   chk_reset_state: assert property ($rose(rstn_in) |->
      ilas_multiframe_groups_out == rst_ilas_count && lane_decoder_core_reset_out) else $error("bad reset state");
   chk_ilas_write: assert property (wr_in && addr_in == adr_ilas_count |=>
      ilas_multiframe_groups_out == $past(wdata_in)) else $error("ilas count not written");
   chk_ilas_read: assert property (rd_in && addr_in == adr_ilas_count |=>
      rdata_out == ilas_multiframe_groups_out) else $error("ilas read mismatch");
   chk_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00) else $error("read data not idle");
   chk_sync_cause: assert property ($rose(sync_request_out) |-> evt_ff <= 4'h6) else $error("sync without cause");
   chk_irq_cause: assert property ($rose(interrupt_out) |-> evt_ff <= 4'h6) else $error("irq without cause");
   chk_report_cause: assert property (error_report_out |-> err_ff <= 4'h5) else $error("report without error");
   chk_sync_hold: assert property (sync_request_out && !touched_ff && !wr_in && !$past(wr_in) &&
      !$past(wr_in, 2) && !$past(wr_in, 3) |=> sync_request_out) else $error("sync dropped");
endmodule
bind slm_monitor slm_props i_props (.clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .bad_disparity_error_in(bad_disparity_error_in), .not_in_table_error_in(not_in_table_error_in),
   .unexpected_control_char_error_in(unexpected_control_char_error_in), .sync_request_out(sync_request_out),
   .interrupt_out(interrupt_out), .ilas_multiframe_groups_out(ilas_multiframe_groups_out),
   .lane_decoder_core_reset_out(lane_decoder_core_reset_out), .error_report_out(error_report_out));

// ===== testbench/slm_xmtr_model.sv
// slm_xmtr_model: transmitter side, pulses the lane 0 error lines
// assumes one-cycle requests from the bench
`timescale 1ns/1ps
module slm_xmtr_model (
   input wire logic clock_in,
   input wire logic [2:0] req_in,
   output logic [2:0] err_out
);
   // bit 0 unexpected control, bit 1 not in table, bit 2 bad disparity
   initial err_out = 3'h0;
   always @(posedge clock_in) err_out <= req_in;
endmodule

// ===== testbench/slm_monitor_tb.sv
// slm_monitor_tb: self-checking bench of the lane error monitor
// assumes the transmitter model drives the lane 0 error lines
`timescale 1ns/1ps
module slm_monitor_tb;
   import slm_pkg::*;
   typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] r; logic [7:0] e;} slm_row_type;
   logic clock_in = 1'b0, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
   logic [11:0] addr_in = 12'h0000;
   logic [7:0] wdata_in = 8'h00, rdata_out, ilas;
   logic [2:0] req = 3'h0, err;
   logic sync_o, irq_o, report, core_rst;
   int n_fail = 0, samples_checked = 0, n = 0;
   slm_row_type rows [5] = '{'{12'h0478, 8'h05, 8'h01, 8'h05}, '{12'h047c, 8'h02, 8'hff, 8'h02},
      '{12'h047d, 8'h0f, 8'h07, 8'h07}, '{12'h0480, 8'hff, 8'h3f, 8'h3f}, '{12'h0123, 8'h55, 8'h00, 8'h00}};
   slm_monitor i_dut (.clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .bad_disparity_error_in(err[2]),
      .not_in_table_error_in(err[1]), .unexpected_control_char_error_in(err[0]), .sync_request_out(sync_o),
      .interrupt_out(irq_o), .ilas_multiframe_groups_out(ilas), .lane_decoder_core_reset_out(core_rst),
      .error_report_out(report));
   slm_xmtr_model i_xmtr (.clock_in(clock_in), .req_in(req), .err_out(err));
   initial forever #5 clock_in = ~clock_in;
   always @(posedge clock_in) if (report === 1'b1) n++;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge clock_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1;
      chk(rdata_out, e);
   endtask
   task automatic pulse(input logic [2:0] m, input int k);
      repeat (k) begin
         @(posedge clock_in);
         req <= m;
         @(posedge clock_in);
         req <= 3'h0;
      end
      repeat (6) @(posedge clock_in);
      #1;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #50000;
      n_fail++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge clock_in);
      rstn_in <= 1'b1;
      rd(adr_link_control_low, 8'h00);
      rd(adr_decoder_control, 8'h08);
      foreach (rows[i]) begin
         rd(rows[i].a, rows[i].r);
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].e);
      end
      chk(ilas, 8'h05);
      $display("register table done");
      wr(adr_irq_enable, 8'h07);
      for (int t = 0; t < 3; t++) begin
         wr(adr_lane0_control, 8'h3f);
         wr(adr_irq_clear, 8'h07);
         wr(adr_lane0_control, 8'h38);
         wr(adr_sync_mask, 8'(1 << t));
         pulse(3'(1 << ((t + 1) % 3)), 2);
         chk({7'h00, sync_o}, 8'h00);
         chk({7'h00, irq_o}, 8'h01);
         pulse(3'(1 << t), 2);
         chk({7'h00, sync_o}, 8'h01);
         rd(adr_lane0_count_base + 12'(t), 8'h02);
      end
      rd(adr_irq_status, 8'h05);
      wr(adr_irq_clear, 8'h07);
      rd(adr_irq_status, 8'h05);
      $display("mask order done");
      wr(adr_lane0_control, 8'h3f);
      wr(adr_lane0_control, 8'h38);
      wr(adr_irq_clear, 8'h07);
      wr(adr_sync_mask, 8'h07);
      chk({7'h00, irq_o}, 8'h00);
      wr(adr_link_control_low, 8'h08);
      pulse(3'h2, 1);
      pulse(3'h4, 2);
      chk({7'h00, irq_o}, 8'h01);
      rd(adr_lane0_count_base + 12'h0002, 8'h00);
      rd(adr_lane0_count_base + 12'h0001, 8'h01);
      $display("auto clear done");
      wr(adr_link_control_low, 8'h00);
      pulse(3'h1, 260);
      rd(adr_lane0_count_base, 8'hff);
      wr(adr_lane0_control, 8'h28);
      n = 0;
      pulse(3'h7, 1);
      chk(8'(n), 8'h01);
      rd(adr_lane0_count_base + 12'h0001, 8'h01);
      $display("count limits done");
      wr(adr_lane0_control, 8'h20);
      pulse(3'h4, 1);
      rd(adr_lane0_count_base + 12'h0002, 8'h01);
      wr(adr_lane0_control, 8'h08);
      pulse(3'h4, 1);
      rd(adr_lane0_count_base + 12'h0002, 8'h02);
      wr(adr_lane0_control, 8'h3c);
      rd(adr_lane0_count_base + 12'h0002, 8'h00);
      rd(adr_lane0_count_base, 8'hff);
      wr(adr_lane0_control, 8'h00);
      n = 0;
      pulse(3'h7, 1);
      chk(8'(n), 8'h00);
      wr(adr_link_control_low, 8'h10);
      n = 0;
      pulse(3'h7, 1);
      chk(8'(n), 8'h01);
      rd(adr_link_control_low, 8'h10);
      wr(adr_link_control_low, 8'h00);
      rd(adr_lane0_count_base + 12'h0001, 8'h01);
      $display("field order done");
      wr(adr_link_page, 8'h01);
      rd(adr_threshold, 8'hff);
      wr(adr_link_page, 8'h00);
      rd(adr_threshold, 8'h02);
      $display("paging done");
      @(posedge clock_in);
      rstn_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      rstn_in <= 1'b1;
      chk(ilas, 8'h01);
      chk({7'h00, core_rst}, 8'h01);
      chk({7'h00, irq_o}, 8'h00);
      rd(adr_threshold, 8'hff);
      rd(adr_link_control_low, 8'h00);
      rd(adr_irq_status, 8'h00);
      $display("mid-run reset done");
      complete_run();
   end
endmodule
